// >>> logic/dhc_pkg.sv
/*
  Package of the debug hold control unit: register offsets, field positions,
  reset values and the power-state enumeration.
  Assumes a 32-bit APB register bus with word-aligned registers.
*/
package dhc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DHC_OFS_IDENT = 8'h00;
  localparam logic [7:0] DHC_OFS_CTL_MAIN = 8'h04;
  localparam logic [7:0] DHC_OFS_CTL_CLOCK = 8'h08;
  localparam logic [31:0] DHC_CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] DHC_ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DHC_BIT_SLEEP_KEEP = 0;
  localparam int DHC_BIT_DEEP_KEEP = 1;
  localparam int DHC_BIT_STANDBY_KEEP = 2;
  localparam int DHC_BIT_FREE_WDG = 8;
  localparam int DHC_BIT_WIN_WDG = 9;
  localparam int DHC_BIT_CNT0 = 11;
  localparam int DHC_BIT_CNT2 = 12;
  localparam int DHC_BIT_CNT13 = 13;
  localparam int DHC_BIT_TW0 = 15;
  localparam int DHC_BIT_TW1 = 16;
  localparam int DHC_BIT_CNT15 = 20;
  localparam int DHC_BIT_CNT16 = 21;
  localparam int DHC_BIT_RTC = 10;

  // Writable bits; reserved bits read as zero.
  localparam logic [31:0] DHC_MASK_MAIN = 32'h0031_BB07;
  localparam logic [31:0] DHC_MASK_CLOCK = 32'h0000_0400;

  // Number of freeze outputs; their order in the freeze vector is set in the freeze gate.
  localparam int DHC_NFRZ = 10;

  // ----------------------------------------------------------------
  // Power states seen by the clock keeper
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DHC_RUN = 4'b0001,
    DHC_SLEEP = 4'b0010,
    DHC_DEEP = 4'b0100,
    DHC_STANDBY = 4'b1000
  } dhc_pstate_t;

endpackage : dhc_pkg

// >>> logic/dhc_ctl_if.sv
/*
  Interface carrying the stored control words from the register file
  to the freeze gate and the clock keeper.
  Assumes all users sit on sys_clk.
*/
`timescale 1ns/1ps
interface dhc_ctl_if;
  logic [31:0] ctl_main;
  logic [31:0] ctl_clock;
  modport src (output ctl_main, output ctl_clock);
  modport dst (input ctl_main, input ctl_clock);
endinterface : dhc_ctl_if

// >>> logic/dhc_freeze_gate.sv
/*
  Freeze gate: one level output per peripheral, AND of its stored bit and
  the synchronised core-halted level.
  Assumes core_halted is already in the sys_clk domain.
*/
`timescale 1ns/1ps
module dhc_freeze_gate
  import dhc_pkg::*;
(
  dhc_ctl_if.dst ctl, // Stored control words.
  input wire logic core_halted, // Synchronised halt level.
  output logic [DHC_NFRZ-1:0] freeze // Freeze levels.
);
  logic [DHC_NFRZ-1:0] sel;
  assign sel = {ctl.ctl_clock[DHC_BIT_RTC], ctl.ctl_main[DHC_BIT_FREE_WDG],
                ctl.ctl_main[DHC_BIT_WIN_WDG], ctl.ctl_main[DHC_BIT_TW0],
                ctl.ctl_main[DHC_BIT_TW1], ctl.ctl_main[DHC_BIT_CNT0],
                ctl.ctl_main[DHC_BIT_CNT2], ctl.ctl_main[DHC_BIT_CNT13],
                ctl.ctl_main[DHC_BIT_CNT15], ctl.ctl_main[DHC_BIT_CNT16]};

  genvar i;
  generate
    for (i = 0; i < DHC_NFRZ; i++) begin : g_frz
      assign freeze[i] = sel[i] & core_halted;
    end
  endgenerate
endmodule : dhc_freeze_gate

// >>> logic/dhc_clock_keep.sv
/*
  Clock keeper: tells the clock unit which clocks stay on in low-power
  modes and raises a system reset request on standby exit.
  Assumes the power state input is synchronised to sys_clk.
*/
`timescale 1ns/1ps
module dhc_clock_keep
  import dhc_pkg::*;
(
  input wire logic sys_clk, // Clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic clk_en, // Clock enable.
  dhc_ctl_if.dst ctl, // Stored control words.
  input wire logic [3:0] pstate, // One-hot power state.
  output logic bus_clk_keep, // Keep bus clock on.
  output logic sys_clk_keep, // Keep system clock on.
  output logic osc48_select, // Source clocks from the 48 MHz oscillator.
  output logic standby_exit_rst // One-cycle system reset request.
);
  dhc_pstate_t st_q;
  logic keep_bus_d;
  logic keep_sys_d;
  logic osc_d;
  logic stb_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) st_q <= DHC_RUN;
    else if (clk_en) st_q <= dhc_pstate_t'(pstate);
  end

  always_comb begin
    keep_bus_d = 1'b0;
    keep_sys_d = 1'b0;
    osc_d = 1'b0;
    case (st_q)
      DHC_RUN: begin
        keep_bus_d = 1'b1;
        keep_sys_d = 1'b1;
      end
      DHC_SLEEP: begin
        keep_bus_d = ctl.ctl_main[DHC_BIT_SLEEP_KEEP];
        keep_sys_d = 1'b1;
      end
      DHC_DEEP: begin
        keep_bus_d = ctl.ctl_main[DHC_BIT_DEEP_KEEP];
        keep_sys_d = ctl.ctl_main[DHC_BIT_DEEP_KEEP];
        osc_d = ctl.ctl_main[DHC_BIT_DEEP_KEEP];
      end
      DHC_STANDBY: begin
        keep_bus_d = ctl.ctl_main[DHC_BIT_STANDBY_KEEP];
        keep_sys_d = ctl.ctl_main[DHC_BIT_STANDBY_KEEP];
        osc_d = ctl.ctl_main[DHC_BIT_STANDBY_KEEP];
      end
      default: begin
        keep_bus_d = 1'b1;
        keep_sys_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_clk_keep <= 1'b1;
      sys_clk_keep <= 1'b1;
      osc48_select <= 1'b0;
    end else if (clk_en) begin
      bus_clk_keep <= keep_bus_d;
      sys_clk_keep <= keep_sys_d;
      osc48_select <= osc_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stb_q <= 1'b0;
      standby_exit_rst <= 1'b0;
    end else if (clk_en) begin
      stb_q <= (st_q == DHC_STANDBY);
      standby_exit_rst <= stb_q & (st_q != DHC_STANDBY);
    end
  end

  chk_standby_exit_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && stb_q && st_q != DHC_STANDBY |=> standby_exit_rst)
    else $error("standby exit gave no reset request");
  chk_deep_osc: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && st_q == DHC_DEEP && ctl.ctl_main[DHC_BIT_DEEP_KEEP] |=> osc48_select && sys_clk_keep)
    else $error("deep sleep clocks not kept");
  chk_sleep_bus: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && st_q == DHC_SLEEP |=> bus_clk_keep == $past(ctl.ctl_main[DHC_BIT_SLEEP_KEEP]))
    else $error("sleep bus clock keep wrong");
  chk_standby_osc: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && st_q == DHC_STANDBY |=> osc48_select == $past(ctl.ctl_main[DHC_BIT_STANDBY_KEEP]))
    else $error("standby oscillator select wrong");
endmodule : dhc_clock_keep

// >>> logic/dhc_top.sv
/*
  Debug hold control unit: identification word, two control registers kept
  over every reset but power reset, freeze outputs and low-power clock keep.
  Assumes an APB master on sys_clk; core_halted and power state arrive from
  other logic and are synchronised here.
*/
`timescale 1ns/1ps
module dhc_top
  import dhc_pkg::*;
#(
  parameter logic [31:0] PART_ID = 32'h0000_1234 // Arbitrary value.
) (
  input wire logic sys_clk, // 10 MHz clock.
  input wire logic rst_n, // System reset, leaves control registers alone.
  input wire logic por_n, // Power reset, synchronous, active low.
  input wire logic clk_en, // Clock enable, freezes all state when low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic core_halted_in, // Core halted level, asynchronous.
  input wire logic [3:0] pstate_in, // One-hot power state, asynchronous.
  output logic frz_counter16, // Counter16 freeze.
  output logic frz_counter15, // Counter15 freeze.
  output logic frz_counter13, // Counter13 freeze.
  output logic frz_counter2, // Counter2 freeze.
  output logic frz_counter0, // Counter0 freeze.
  output logic frz_two_wire1, // Two-wire 1 timeout freeze.
  output logic frz_two_wire0, // Two-wire 0 timeout freeze.
  output logic frz_window_wdg, // Window watchdog clock freeze.
  output logic frz_free_wdg, // Free watchdog clock freeze.
  output logic frz_rtc, // Real-time clock counter freeze.
  output logic bus_clk_keep, // Keep bus clock on.
  output logic sys_clk_keep, // Keep system clock on.
  output logic osc48_select, // Use the 48 MHz oscillator.
  output logic standby_exit_rst // System reset request pulse.
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic halt_s1_q;
  logic halt_s2_q;
  logic [3:0] ps_s1_q;
  logic [3:0] ps_s2_q;

  always_ff @(posedge sys_clk) begin
    if (!por_n) begin
      halt_s1_q <= 1'b0;
      halt_s2_q <= 1'b0;
      ps_s1_q <= 4'h1;
      ps_s2_q <= 4'h1;
    end else if (clk_en) begin
      halt_s1_q <= core_halted_in;
      halt_s2_q <= halt_s1_q;
      ps_s1_q <= pstate_in;
      ps_s2_q <= ps_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  dhc_ctl_if ctl_bus ();
  logic [31:0] ctl_main_q;
  logic [31:0] ctl_clock_q;
  logic wr_en;
  logic addr_hit;

  assign wr_en = psel & penable & pwrite & clk_en;
  assign addr_hit = (paddr == DHC_OFS_IDENT) | (paddr == DHC_OFS_CTL_MAIN) |
                    (paddr == DHC_OFS_CTL_CLOCK);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  always_ff @(posedge sys_clk) begin
    if (!por_n) begin
      ctl_main_q <= DHC_CTL_RESET;
      ctl_clock_q <= DHC_CTL_RESET;
    end else if (wr_en) begin
      if (paddr == DHC_OFS_CTL_MAIN) ctl_main_q <= pwdata & DHC_MASK_MAIN;
      if (paddr == DHC_OFS_CTL_CLOCK) ctl_clock_q <= pwdata & DHC_MASK_CLOCK;
    end
  end

  always_comb begin
    case (paddr)
      DHC_OFS_IDENT: prdata = PART_ID;
      DHC_OFS_CTL_MAIN: prdata = ctl_main_q;
      DHC_OFS_CTL_CLOCK: prdata = ctl_clock_q;
      default: prdata = DHC_ZERO_WORD;
    endcase
  end

  assign ctl_bus.ctl_main = ctl_main_q;
  assign ctl_bus.ctl_clock = ctl_clock_q;

  // ----------------------------------------------------------------
  // Freeze outputs
  // ----------------------------------------------------------------
  logic [DHC_NFRZ-1:0] frz;

  dhc_freeze_gate u_gate (
    .ctl(ctl_bus),
    .core_halted(halt_s2_q),
    .freeze(frz)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !por_n) begin
      {frz_rtc, frz_free_wdg, frz_window_wdg, frz_two_wire0, frz_two_wire1,
       frz_counter0, frz_counter2, frz_counter13, frz_counter15, frz_counter16} <= '0;
    end else if (clk_en) begin
      {frz_rtc, frz_free_wdg, frz_window_wdg, frz_two_wire0, frz_two_wire1,
       frz_counter0, frz_counter2, frz_counter13, frz_counter15, frz_counter16} <= frz;
    end
  end

  // ----------------------------------------------------------------
  // Low-power clock keeping
  // ----------------------------------------------------------------
  dhc_clock_keep u_keep (
    .sys_clk(sys_clk),
    .rst_n(rst_n & por_n),
    .clk_en(clk_en),
    .ctl(ctl_bus),
    .pstate(ps_s2_q),
    .bus_clk_keep(bus_clk_keep),
    .sys_clk_keep(sys_clk_keep),
    .osc48_select(osc48_select),
    .standby_exit_rst(standby_exit_rst)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ident_const: assert property (@(posedge sys_clk) disable iff (!por_n)
    psel && !pwrite && paddr == DHC_OFS_IDENT |-> prdata == PART_ID)
    else $error("identification word changed");
  chk_ctl_keep_sysrst: assert property (@(posedge sys_clk) disable iff (!por_n)
    !rst_n && !wr_en |=> ctl_main_q == $past(ctl_main_q))
    else $error("system reset altered control register");
  chk_ctl_por_zero: assert property (@(posedge sys_clk)
    !por_n |=> ctl_main_q == DHC_CTL_RESET && ctl_clock_q == DHC_CTL_RESET)
    else $error("power reset did not clear control");
  chk_freeze_halt: assert property (@(posedge sys_clk) disable iff (!rst_n || !por_n)
    clk_en && !halt_s2_q |=> !frz_counter0 && !frz_rtc && !frz_free_wdg)
    else $error("freeze while core running");
  chk_cnt16_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n || !por_n)
    clk_en |=> frz_counter16 == $past(ctl_main_q[DHC_BIT_CNT16] & halt_s2_q))
    else $error("counter16 freeze mismatch");
  chk_tw1_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n || !por_n)
    clk_en |=> frz_two_wire1 == $past(ctl_main_q[DHC_BIT_TW1] & halt_s2_q))
    else $error("two-wire 1 freeze mismatch");
  chk_wwdg_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n || !por_n)
    clk_en |=> frz_window_wdg == $past(ctl_main_q[DHC_BIT_WIN_WDG] & halt_s2_q))
    else $error("window watchdog freeze mismatch");
  chk_rtc_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n || !por_n)
    clk_en |=> frz_rtc == $past(ctl_clock_q[DHC_BIT_RTC] & halt_s2_q))
    else $error("real-time clock freeze mismatch");
  chk_cnt0_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n || !por_n)
    clk_en |=> frz_counter0 == $past(ctl_main_q[DHC_BIT_CNT0] & halt_s2_q))
    else $error("counter0 freeze mismatch");

endmodule : dhc_top

// >>> tb/dhc_probe_model.sv
/*
  Probe model: the debug tool's word-wide path into the registers, as an APB master.
  Assumes a slave on sys_clk that may stretch the access phase with pready.
*/
`timescale 1ns/1ps
module dhc_probe_model (
  input wire logic sys_clk, // Clock.
  input wire logic pready, // Slave ready.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pslverr, // Slave error.
  output logic psel, // Select.
  output logic penable, // Enable.
  output logic pwrite, // Direction.
  output logic [7:0] paddr, // Byte address.
  output logic [31:0] pwdata // Write data.
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Transfer
  // ----------------------------------------------------------------
  // whole word access
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rdata, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data is inverted so a stale value cannot pass for a new one.
    pwdata <= ~d;
  endtask : xfer
endmodule : dhc_probe_model

// >>> tb/testbench.sv
/*
  Testbench of the debug hold control unit: registers, freeze gating, resets and clock keep.
  Assumes the probe model as APB master and a 10 MHz sys_clk.
*/
`timescale 1ns/1ps
module testbench;
  import dhc_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h0000_5A5A; // Arbitrary value.
  logic sys_clk, rst_n, por_n, clk_en, psel, penable, pwrite, pready, pslverr, core_halted_in, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] pstate_in;
  logic frz_counter16, frz_counter15, frz_counter13, frz_counter2, frz_counter0;
  logic frz_two_wire1, frz_two_wire0, frz_window_wdg, frz_free_wdg, frz_rtc;
  logic bus_clk_keep, sys_clk_keep, osc48_select, standby_exit_rst;
  logic [9:0] frz;
  int failures = 0;
  int total_checks = 0;
  int pulses = 0;
  int pos[9] = '{21, 20, 13, 12, 11, 16, 15, 9, 8};
  assign frz = {frz_counter16, frz_counter15, frz_counter13, frz_counter2, frz_counter0,
                frz_two_wire1, frz_two_wire0, frz_window_wdg, frz_free_wdg, frz_rtc};

  dhc_top #(.PART_ID(ID_VAL)) dut (.sys_clk, .rst_n, .por_n, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .core_halted_in, .pstate_in, .frz_counter16, .frz_counter15,
    .frz_counter13, .frz_counter2, .frz_counter0, .frz_two_wire1, .frz_two_wire0, .frz_window_wdg,
    .frz_free_wdg, .frz_rtc, .bus_clk_keep, .sys_clk_keep, .osc48_select, .standby_exit_rst);
  dhc_probe_model probe (.sys_clk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (standby_exit_rst === 1'b1) pulses++;
  end

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_clk

  task wr(input logic [7:0] a, input logic [31:0] d);
    probe.xfer(1'b1, a, d, rv, er);
  endtask : wr

  task rd(input logic [7:0] a);
    probe.xfer(1'b0, a, 32'h0000_0000, rv, er);
  endtask : rd

  task halt(input logic h);
    @(posedge sys_clk);
    core_halted_in <= h;
    wait_clk(4);
  endtask : halt

  task ps(input logic [3:0] p, input logic [2:0] e);
    @(posedge sys_clk);
    pstate_in <= p;
    wait_clk(6);
    chk("clock keep", {29'h0000_0000, bus_clk_keep, sys_clk_keep, osc48_select}, {29'h0000_0000, e});
  endtask : ps

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    wr(DHC_OFS_IDENT, 32'hFFFF_FFFF);
    rd(DHC_OFS_IDENT);
    chk("ident", rv, ID_VAL);
    rd(DHC_OFS_CTL_MAIN);
    chk("main reset", rv, 32'h0000_0000);
    rd(DHC_OFS_CTL_CLOCK);
    chk("clock reset", rv, 32'h0000_0000);
    rd(8'h0C);
    chk("unmapped", {er, rv}, 33'h1_0000_0000);
  endtask : t_regs

  task t_map;
    halt(1'b1);
    for (int i = 0; i < 9; i++) begin
      wr(DHC_OFS_CTL_MAIN, 32'h0000_0001 << pos[i]);
      rd(DHC_OFS_CTL_MAIN);
      chk("main bit", rv, 32'h0000_0001 << pos[i]);
      wait_clk(2);
      chk("freeze map", {22'h00_0000, frz}, 32'h0000_0200 >> i);
    end
    wr(DHC_OFS_CTL_MAIN, 32'h0000_0000);
    wr(DHC_OFS_CTL_CLOCK, 32'hFFFF_FFFF);
    wait_clk(2);
    chk("rtc freeze", {22'h00_0000, frz}, 32'h0000_0001);
  endtask : t_map

  task t_gate;
    wr(DHC_OFS_CTL_MAIN, 32'hFFFF_FFFF);
    wait_clk(2);
    chk("all frozen", {22'h00_0000, frz}, 32'h0000_03FF);
    halt(1'b0);
    chk("not halted", {22'h00_0000, frz}, 32'h0000_0000);
    rd(DHC_OFS_CTL_MAIN);
    chk("main mask", rv, 32'h0031_BB07);
    rd(DHC_OFS_CTL_CLOCK);
    chk("clock mask", rv, 32'h0000_0400);
  endtask : t_gate

  task t_resets;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    wait_clk(3);
    rst_n <= 1'b1;
    rd(DHC_OFS_CTL_MAIN);
    chk("kept over reset", rv, 32'h0031_BB07);
    @(posedge sys_clk);
    por_n <= 1'b0;
    wait_clk(3);
    por_n <= 1'b1;
    rd(DHC_OFS_CTL_CLOCK);
    chk("power reset", rv, 32'h0000_0000);
  endtask : t_resets

  task t_enable;
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(DHC_OFS_CTL_MAIN, 32'h0000_0100);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(DHC_OFS_CTL_MAIN);
    chk("frozen write", rv, 32'h0000_0000);
    wr(DHC_OFS_CTL_MAIN, 32'h0000_0100);
    rd(DHC_OFS_CTL_MAIN);
    chk("enabled write", rv, 32'h0000_0100);
  endtask : t_enable

  task t_power;
    wr(DHC_OFS_CTL_MAIN, 32'h0000_0007);
    pulses = 0;
    ps(DHC_RUN, 3'b110);
    ps(DHC_SLEEP, 3'b110);
    ps(DHC_DEEP, 3'b111);
    ps(DHC_STANDBY, 3'b111);
    ps(DHC_RUN, 3'b110);
    chk("exit pulse", pulses, 32'h0000_0001);
    wr(DHC_OFS_CTL_MAIN, 32'h0000_0000);
    ps(DHC_SLEEP, 3'b010);
    ps(DHC_DEEP, 3'b000);
    ps(DHC_STANDBY, 3'b000);
    ps(DHC_RUN, 3'b110);
    chk("exit pulses", pulses, 32'h0000_0002);
  endtask : t_power

  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    clk_en = 1'b1;
    core_halted_in = 1'b0;
    pstate_in = 4'b0001;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    t_regs;
    t_map;
    t_gate;
    t_resets;
    t_enable;
    t_power;
    give_verdict;
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    give_verdict;
  end
endmodule : testbench
